// >>> src/tmr_evt_pkg.sv
/*
  Constants for the timer event request logic: sizes, register offsets,
  status bit layout, reset values, pin actions and source priority order.
  Assumes a five-channel timer whose counters and compare values come
  from elsewhere on the same clock.
*/
package tmr_evt_pkg;
  localparam int NUM_CH    = 5;
  localparam int NUM_MATCH = 16;
  localparam int NUM_FLAGS = 23;
  localparam int NUM_XFER  = 17;
  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] ENABLE_OFS    = 8'h04;
  localparam logic [ADDR_W-1:0] CONV_EN_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] PIN_CTRL_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] PIN_STATE_OFS = 8'h10;

  localparam int OVF_LSB = 16;
  localparam int UNF_LSB = 21;
  localparam int OVF4_BIT = 20;

  localparam logic [NUM_FLAGS-1:0] STATUS_RST   = 23'h000000;
  localparam logic [NUM_FLAGS-1:0] ENABLE_RST   = 23'h000000;
  localparam logic [NUM_CH-1:0]    CONV_EN_RST  = 5'h00;
  localparam logic [31:0]          PIN_CTRL_RST = 32'h00000000;
  localparam logic [NUM_MATCH-1:0] PIN_RST      = 16'h0000;

  typedef enum logic [1:0] {
    PIN_KEEP   = 2'b00,
    PIN_LOW    = 2'b01,
    PIN_HIGH   = 2'b10,
    PIN_TOGGLE = 2'b11
  } pin_action_e;

  // channel owning each compare register
  localparam int MATCH_CHAN [NUM_MATCH] = '{0, 0, 0, 0, 1, 1, 2, 2,
                                            3, 3, 3, 3, 4, 4, 4, 4};
  localparam int REG_A_IDX [NUM_CH] = '{0, 4, 6, 8, 12};
  // status bits from highest to lowest priority
  localparam int PRIO_ORDER [NUM_FLAGS] = '{0, 1, 2, 3, 16, 4, 5, 17, 21,
                                            6, 7, 18, 22, 8, 9, 10, 11, 19,
                                            12, 13, 14, 15, 20};
endpackage : tmr_evt_pkg

// >>> src/timer_event_request_logic.sv
/*
  Event flags, interrupt requests, transfer/DMA/converter triggers and
  compare output pins of a five-channel timer.
  Assumes counters, compare values and capture/overflow/underflow pulses
  come from timer logic on core_clk; acks are one-cycle pulses.
*/
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module timer_event_request_logic
  import tmr_evt_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic [ADDR_W-1:0]      bus_addr,
  input  wire logic [DATA_W-1:0]      bus_wdata,
  input  wire logic                   bus_write,
  input  wire logic                   bus_read,
  output logic      [DATA_W-1:0]      bus_rdata,
  input  wire logic [NUM_CH*CW-1:0]   count_reg,
  input  wire logic [NUM_CH-1:0]      count_tick,
  input  wire logic [NUM_MATCH*CW-1:0] general_compare_reg,
  input  wire logic [NUM_MATCH-1:0]   compare_mode,
  input  wire logic [NUM_MATCH-1:0]   capture_event,
  input  wire logic [NUM_CH-1:0]      overflow_event,
  input  wire logic [1:0]             underflow_event,
  input  wire logic                   ch4_underflow_event,
  input  wire logic [NUM_XFER-1:0]    transfer_ack,
  input  wire logic [NUM_CH-1:0]      dma_ack,
  output logic      [NUM_MATCH-1:0]   match_request,
  output logic      [NUM_CH-1:0]      overflow_request,
  output logic      [1:0]             underflow_request,
  output logic      [NUM_XFER-1:0]    transfer_request,
  output logic      [NUM_CH-1:0]      dma_request,
  output logic                        conversion_start,
  output logic      [NUM_MATCH-1:0]   compare_match,
  output logic      [NUM_MATCH-1:0]   timer_io_pin,
  output logic                        irq,
  output logic                        prio_valid,
  output logic      [4:0]             prio_source
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic [NUM_FLAGS-1:0] flag;
  logic [NUM_FLAGS-1:0] enable;
  logic [NUM_FLAGS-1:0] read_seen;
  logic [NUM_CH-1:0]    conv_en;
  logic [31:0]          pin_ctrl;

  wire st_sel = (bus_addr == STATUS_OFS);
  wire en_sel = (bus_addr == ENABLE_OFS);
  wire cv_sel = (bus_addr == CONV_EN_OFS);
  wire pc_sel = (bus_addr == PIN_CTRL_OFS);
  wire ps_sel = (bus_addr == PIN_STATE_OFS);
  wire st_wr  = st_sel & bus_write;

  // compare match only on a counter tick, so one per count value
  wire [NUM_MATCH-1:0] match_hit;
  wire [NUM_MATCH-1:0] match_tick;
  genvar gi;
  for (gi = 0; gi < NUM_MATCH; gi++) begin : g_cmp
    localparam int CH = MATCH_CHAN[gi];
    assign match_tick[gi] = count_tick[CH];
    assign match_hit[gi]  = compare_mode[gi] & count_tick[CH] &
                            (count_reg[CH*CW +: CW] ==
                             general_compare_reg[gi*CW +: CW]);
  end

  wire [NUM_MATCH-1:0] cap_hit = capture_event & ~compare_mode;
  wire [NUM_CH-1:0] ovf_set = {overflow_event[4] | ch4_underflow_event,
                               overflow_event[3:0]};
  wire [NUM_FLAGS-1:0] flag_set = {underflow_event,
                                   ovf_set,
                                   match_hit | cap_hit};

  // a zero only clears a bit that the last status read showed as one
  wire [NUM_FLAGS-1:0] sw_clear = st_wr ?
                                  (read_seen & ~bus_wdata[NUM_FLAGS-1:0]) :
                                  STATUS_RST;

  logic [NUM_FLAGS-1:0] hw_clear;
  always_comb begin
    hw_clear = STATUS_RST;
    hw_clear[NUM_MATCH-1:0] = transfer_ack[NUM_MATCH-1:0];
    hw_clear[OVF4_BIT] = transfer_ack[NUM_XFER-1];
    for (int k = 0; k < NUM_CH; k++) begin
      hw_clear[REG_A_IDX[k]] = hw_clear[REG_A_IDX[k]] | dma_ack[k];
    end
  end

  // set wins over any clear in the same cycle
  wire [NUM_FLAGS-1:0] next_flag = (flag & ~(sw_clear | hw_clear)) |
                                   flag_set;
  wire [NUM_FLAGS-1:0] next_enable = (en_sel & bus_write) ?
                                     bus_wdata[NUM_FLAGS-1:0] : enable;
  wire [NUM_FLAGS-1:0] next_req = next_flag & next_enable;

  logic [NUM_CH-1:0] rega_rise;
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      rega_rise[k] = flag_set[REG_A_IDX[k]] & ~flag[REG_A_IDX[k]];
    end
  end
  wire next_conv = |(rega_rise & conv_en);

  logic [NUM_CH-1:0] next_dma;
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      next_dma[k] = next_req[REG_A_IDX[k]];
    end
  end

  // walk from lowest to highest so the highest pending source wins
  logic       next_pv;
  logic [4:0] next_ps;
  always_comb begin
    next_pv = 1'b0;
    next_ps = 5'h00;
    for (int p = NUM_FLAGS - 1; p >= 0; p--) begin
      if (next_req[PRIO_ORDER[p]]) begin
        next_pv = 1'b1;
        next_ps = 5'(PRIO_ORDER[p]);
      end
    end
  end

  logic [NUM_MATCH-1:0] next_pin;
  always_comb begin
    for (int i = 0; i < NUM_MATCH; i++) begin
      next_pin[i] = timer_io_pin[i];
      if (match_hit[i]) begin
        case (pin_action_e'(pin_ctrl[2*i +: 2]))
          PIN_LOW:    next_pin[i] = 1'b0;
          PIN_HIGH:   next_pin[i] = 1'b1;
          PIN_TOGGLE: next_pin[i] = ~timer_io_pin[i];
          default:    next_pin[i] = timer_io_pin[i];
        endcase
      end
    end
  end

  wire [DATA_W-1:0] read_mux =
    st_sel ? {9'h000, flag} :
    en_sel ? {9'h000, enable} :
    cv_sel ? {27'h0000000, conv_en} :
    pc_sel ? pin_ctrl :
    ps_sel ? {16'h0000, timer_io_pin} :
    32'h00000000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag      <= STATUS_RST;
      enable    <= ENABLE_RST;
      read_seen <= STATUS_RST;
    end else begin
      flag   <= next_flag;
      enable <= next_enable;
      if (st_wr) begin
        read_seen <= STATUS_RST;
      end else if (st_sel & bus_read) begin
        read_seen <= flag;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_en  <= CONV_EN_RST;
      pin_ctrl <= PIN_CTRL_RST;
    end else begin
      if (cv_sel & bus_write) begin
        conv_en <= bus_wdata[NUM_CH-1:0];
      end
      if (pc_sel & bus_write) begin
        pin_ctrl <= bus_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= bus_read ? read_mux : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      match_request     <= 16'h0000;
      overflow_request  <= 5'h00;
      underflow_request <= 2'h0;
      transfer_request  <= 17'h00000;
      dma_request       <= 5'h00;
      irq               <= 1'b0;
      prio_valid        <= 1'b0;
      prio_source       <= 5'h00;
    end else begin
      match_request     <= next_req[NUM_MATCH-1:0];
      overflow_request  <= next_req[UNF_LSB-1:OVF_LSB];
      underflow_request <= next_req[NUM_FLAGS-1:UNF_LSB];
      transfer_request  <= {next_req[OVF4_BIT],
                            next_req[NUM_MATCH-1:0]};
      dma_request       <= next_dma;
      irq               <= |next_req;
      prio_valid        <= next_pv;
      prio_source       <= next_ps;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conversion_start <= 1'b0;
      compare_match    <= 16'h0000;
      timer_io_pin     <= PIN_RST;
    end else begin
      conversion_start <= next_conv;
      compare_match    <= match_hit;
      timer_io_pin     <= next_pin;
    end
  end

  wire [NUM_FLAGS-1:0] req_all = {underflow_request, overflow_request,
                                  match_request};

  a_req_is_and: assert property (req_all == (flag & enable))
    else $error("request differs from flag and enable");

  a_req_drops: assert property (
    (|($past(flag) & ~flag)) |-> ((req_all & ~flag) == 23'h000000))
    else $error("request outlived its cleared flag");

  a_flag_sets: assert property (
    (|flag_set) |=> ((flag & $past(flag_set)) == $past(flag_set)))
    else $error("event did not set its flag");

  a_sw_clear: assert property (
    st_wr |=> ((flag & $past(sw_clear & ~flag_set)) == 23'h000000))
    else $error("read-then-zero write did not clear flag");

  a_blind_write: assert property (
    st_wr |=> ((flag & $past(flag & ~read_seen & ~hw_clear)) ==
               $past(flag & ~read_seen & ~hw_clear)))
    else $error("flag cleared without a prior read");

  a_ack_clears: assert property (
    (|hw_clear) |=> ((flag & $past(hw_clear & ~flag_set)) == 23'h000000))
    else $error("activation ack did not clear flag");

  a_dma_map: assert property (dma_request == {match_request[12],
    match_request[8], match_request[6], match_request[4], match_request[0]})
    else $error("dma request not from register A only");

  a_xfer_map: assert property (
    transfer_request == {overflow_request[4], match_request})
    else $error("transfer request map wrong");

  sequence s_rega_set;
    |(rega_rise & conv_en);
  endsequence
  sequence s_conv_pulse;
    conversion_start ##1 !conversion_start [*1];
  endsequence
  a_conv_start: assert property (
    s_rega_set ##1 !(|(rega_rise & conv_en)) |-> s_conv_pulse)
    else $error("conversion start missing or too long");

  a_match_tick: assert property (
    (|compare_match) |-> ((compare_match & ~$past(match_tick)) == 16'h0000))
    else $error("compare match without a counter tick");

  a_prio_top: assert property (
    match_request[0] |-> (prio_valid && prio_source == 5'h00))
    else $error("channel 0 A did not win priority");

  a_prio_ovf0: assert property (
    (overflow_request[0] && match_request[3:0] == 4'h0) |->
    prio_source == 5'h10)
    else $error("channel 0 overflow order wrong");

  for (gi = 0; gi < NUM_MATCH; gi++) begin : g_chk
    a_pin_high: assert property (
      (match_hit[gi] && pin_ctrl[2*gi +: 2] == PIN_HIGH) |=>
      (timer_io_pin[gi] && compare_match[gi]))
      else $error("pin not driven high on match");
    a_match_when: assert property (
      (compare_mode[gi] && match_tick[gi] &&
       count_reg[MATCH_CHAN[gi]*CW +: CW] == general_compare_reg[gi*CW +: CW])
      |=> compare_match[gi])
      else $error("compare match missed");
  end

endmodule : timer_event_request_logic

// >>> testbench/event_partner.sv
/*
  Far-side model: transfer and DMA controllers that acknowledge requests,
  and a converter that counts starts when it has picked the timer trigger.
  Assumes the block's registered request levels and one clock.
*/
`timescale 1ns/1ps
module event_partner (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [16:0] transfer_request,
  input  wire logic [4:0]  dma_request,
  input  wire logic        conversion_start,
  input  wire logic        auto_ack,
  input  wire logic        adc_select,
  output logic      [16:0] transfer_ack,
  output logic      [4:0]  dma_ack,
  output logic      [7:0]  conv_count
);
  // one-cycle acks; the mask stops a second ack while the request drops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      transfer_ack <= '0;
      dma_ack      <= '0;
      conv_count   <= '0;
    end else begin
      transfer_ack <= auto_ack ? (transfer_request & ~transfer_ack) : '0;
      dma_ack      <= auto_ack ? (dma_request & ~dma_ack) : '0;
      if (conversion_start && adc_select) begin
        conv_count <= conv_count + 8'h01;
      end
    end
  end
endmodule : event_partner

// >>> testbench/timer_event_request_logic_bench.sv
/*
  Self-checking bench: register tasks, event pulses, flag clearing,
  priority, transfer/DMA acks and compare match output.
  Assumes the event partner model and a 40 MHz core_clk.
*/
`timescale 1ns/1ps
module timer_event_request_logic_bench;
  import tmr_evt_pkg::*;
  logic                       core_clk = 0, reset = 1, bus_write = 0, bus_read = 0;
  logic                       ch4_uf = 0, auto_ack = 0, adc_select = 0, conv_start, irq, prio_valid;
  logic [ADDR_W-1:0]          bus_addr = '0;
  logic [DATA_W-1:0]          bus_wdata = '0, d, bus_rdata;
  logic [NUM_CH*CNT_W-1:0]    count_reg = '0;
  logic [NUM_MATCH*CNT_W-1:0] gcr = '0;
  logic [NUM_CH-1:0]          count_tick = '0, overflow_event = '0, dma_ack, dma_request, ovf_req;
  logic [15:0]                compare_mode = '0, capture_event = '0, mreq, cmatch, pins;
  logic [1:0]                 underflow_event = '0, ureq;
  logic [16:0]                transfer_ack, transfer_request;
  logic [4:0]                 prio_source;
  logic [7:0]                 conv_count;
  logic [22:0]                reqs;
  int                         failures = 0, samples_checked = 0, cycles = 0;

  assign reqs = {ureq, ovf_req, mreq};
  always #12.5 core_clk = ~core_clk;

  timer_event_request_logic uut (.core_clk(core_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .count_reg(count_reg), .count_tick(count_tick), .general_compare_reg(gcr),
    .compare_mode(compare_mode), .capture_event(capture_event), .overflow_event(overflow_event),
    .underflow_event(underflow_event), .ch4_underflow_event(ch4_uf), .transfer_ack(transfer_ack),
    .dma_ack(dma_ack), .match_request(mreq), .overflow_request(ovf_req), .underflow_request(ureq),
    .transfer_request(transfer_request), .dma_request(dma_request), .conversion_start(conv_start),
    .compare_match(cmatch), .timer_io_pin(pins), .irq(irq), .prio_valid(prio_valid),
    .prio_source(prio_source));
  event_partner partner (.core_clk(core_clk), .reset(reset), .transfer_request(transfer_request),
    .dma_request(dma_request), .conversion_start(conv_start), .auto_ack(auto_ack),
    .adc_select(adc_select), .transfer_ack(transfer_ack), .dma_ack(dma_ack), .conv_count(conv_count));

  task results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_write <= 1;
    @(posedge core_clk);
    bus_write <= 0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_addr <= a;
    bus_read <= 1;
    @(posedge core_clk);
    bus_read <= 0;
    #1 d = bus_rdata;
  endtask : rd

  // clear every flag set: read, then write zero
  task clr;
    rd(STATUS_OFS);
    wr(STATUS_OFS, 32'h00000000);
    @(posedge core_clk);
    #1;
  endtask : clr

  // source 23 stands for the channel 4 underflow pulse
  task fire(input int b);
    @(posedge core_clk);
    if (b < 16) capture_event[b] <= 1;
    else if (b < 21) overflow_event[b-16] <= 1;
    else if (b < 23) underflow_event[b-21] <= 1;
    else ch4_uf <= 1;
    @(posedge core_clk);
    capture_event   <= '0;
    overflow_event  <= '0;
    underflow_event <= '0;
    ch4_uf          <= 0;
    #1;
  endtask : fire

  task tick;
    @(posedge core_clk);
    count_tick[0] <= 1;
    @(posedge core_clk);
    count_tick[0] <= 0;
    #1;
  endtask : tick

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  initial begin
    int idx;
    repeat (10) @(posedge core_clk);
    reset <= 0;
    for (int i = 0; i < 6; i++) begin
      rd(i * 4);
      chk(d, 32'h00000000);
    end
    $display("reset values done");
    fire(16);
    rd(STATUS_OFS);
    chk(d, 32'h00010000);
    chk(reqs, 23'h000000);
    wr(ENABLE_OFS, 32'h007FFFFF);
    @(posedge core_clk);
    #1;
    chk(reqs, 23'h010000);
    chk(irq, 1);
    wr(STATUS_OFS, 32'h007FFFFF);
    wr(STATUS_OFS, 32'h00000000);
    @(posedge core_clk);
    #1;
    chk(reqs, 23'h010000);
    clr();
    chk(reqs, 23'h000000);
    chk(irq, 0);
    $display("flag gating done");
    for (int b = 0; b < 24; b++) begin
      idx = (b == 23) ? 20 : b;
      fire(b);
      chk(reqs, 32'h1 << idx);
      chk(transfer_request, idx < 16 ? 32'h1 << idx : (idx == 20 ? 32'h10000 : 0));
      chk(dma_request, idx == 0 ? 1 : idx == 4 ? 2 : idx == 6 ? 4 : idx == 8 ? 8 : idx == 12 ? 16 : 0);
      chk(prio_source, idx);
      clr();
    end
    $display("sources done");
    fire(21);
    fire(4);
    chk(prio_source, 4);
    fire(16);
    chk(prio_source, 16);
    fire(3);
    chk(prio_source, 3);
    chk(prio_valid, 1);
    clr();
    chk(prio_valid, 0);
    $display("priority done");
    auto_ack <= 1;
    fire(5);
    fire(12);
    fire(16);
    repeat (3) @(posedge core_clk);
    rd(STATUS_OFS);
    chk(d, 32'h00010000);
    auto_ack <= 0;
    clr();
    $display("acks done");
    wr(PIN_CTRL_OFS, 32'h00000002);
    wr(CONV_EN_OFS, 32'h00000001);
    compare_mode    <= 16'h0001;
    gcr[15:0]       <= 16'h0005;
    count_reg[15:0] <= 16'h0005;
    adc_select      <= 1;
    tick();
    chk(cmatch, 1);
    chk(pins, 1);
    chk(conv_start, 1);
    repeat (3) begin
      @(posedge core_clk);
      #1;
      chk(cmatch, 0);
    end
    chk(conv_count, 1);
    // keep must hold a high pin, low must then pull it down
    wr(PIN_CTRL_OFS, 32'h00000000);
    tick();
    chk(pins, 1);
    wr(PIN_CTRL_OFS, 32'h00000001);
    tick();
    chk(pins, 0);
    rd(STATUS_OFS);
    chk(d, 32'h00000001);
    clr();
    wr(PIN_CTRL_OFS, 32'h00000003);
    adc_select <= 0;
    tick();
    chk(pins, 1);
    repeat (3) @(posedge core_clk);
    #1;
    chk(conv_count, 1);
    $display("compare done");
    // reset in mid-run with a flag, a request and a pin still high
    @(posedge core_clk);
    reset <= 1;
    repeat (2) @(posedge core_clk);
    reset <= 0;
    #1;
    chk(reqs, 23'h000000);
    chk(irq, 0);
    chk(prio_valid, 0);
    chk(pins, 0);
    for (int i = 0; i < 5; i++) begin
      rd(i * 4);
      chk(d, 32'h00000000);
    end
    $display("second reset done");
    results();
  end
endmodule : timer_event_request_logic_bench
